// File: logic/csb_bus_ctrl.sv
// CPU system bus control: address, data, strobes, hold, wait.
// Assumes synchronous pins, external pull-ups on shared lines.
//
// Summary of operation
// R1 - Drive 16-bit address; refresh addresses during refresh cycles.
// R2 - Address lines become inputs during outside master peripheral access.
// R3 - Data bus outputs peripheral data on internal peripheral access.
// R4 - Read, store and I/O request become inputs for outside master.
// R5 - Store strobe asserted while write data is on data bus.
// R6 - Memory request low while valid memory address present.
// R7 - Memory request floats during outside master peripheral access.
// R8 - I/O request low while I/O address on low eight bits.
// R9 - Interrupt acknowledge asserts I/O request with opcode-fetch; vector read.
// R10 - Opcode-fetch asserted with memory request on every fetch.
// R11 - Emulation mode floats opcode-fetch, refresh and halt outputs.
// R12 - Refresh indicator with memory request while refresh address out.
// R13 - Maskable interrupt accepted only with enable flag set.
// R14 - Peripheral interrupts wire-ORed on open-drain pin, external pull-up.
// R15 - NMI wins over maskable and ignores enable flag.
// R16 - Halt output signals executed halt instruction.
// R17 - Other party asserts wired-OR bus hold request to float bus.
// R18 - Hold grant only after bus and strobes are floated.
// R19 - One variant floats hold grant in emulation mode.
// R20 - Processor waits while wait input stays active.
// R21 - One variant drives wait pin from on-chip generator in emulation.
// R22 - Finish current bus cycle before floating and granting hold.
`timescale 1ns/1ps
`default_nettype none
`include "csb_defines.svh"
module csb_bus_ctrl
  import csb_pkg::*;
#(
  parameter bit FLOAT_GRANT_IN_EMU = 1'b1  // Variant select
)
(
  input  wire logic                   clk_in,           // System clock
  input  wire logic                   sys_rst_in,       // Sync reset, high
  input  wire logic                   req_valid_in,     // Core cycle request
  input  wire logic [2:0]             req_kind_in,      // Cycle kind
  input  wire logic [`CSB_ADDR_W-1:0] req_addr_in,      // Cycle address
  input  wire logic [`CSB_DATA_W-1:0] req_wdata_in,     // Write data
  input  wire logic                   req_onchip_in,    // Target on-chip peripheral
  input  wire logic [`CSB_DATA_W-1:0] periph_rdata_in,  // On-chip read data
  input  wire logic                   refresh_req_in,   // Refresh slot request
  input  wire logic                   halt_in,          // Halt executed
  input  wire logic                   ie_flag_in,       // Interrupt enable flag
  input  wire logic                   periph_int_in,    // On-chip interrupt
  input  wire logic                   ext_access_in,    // Outside master on peripherals
  input  wire logic                   emu_mode_in,      // Emulation mode
  input  wire logic                   emu_wait_gen_in,  // On-chip wait generator
  input  wire logic [`CSB_ADDR_W-1:0] addr_in,          // Address pins in
  input  wire logic [`CSB_DATA_W-1:0] data_in,          // Data pins in
  input  wire logic                   rd_n_in,          // Read strobe in
  input  wire logic                   wr_n_in,          // Store strobe in
  input  wire logic                   io_request_n_in,  // I/O request in
  input  wire logic                   int_n_in,         // Interrupt pin level
  input  wire logic                   nmi_n_in,         // Non-maskable request
  input  wire logic                   bus_hold_request_n_in, // Hold request
  input  wire logic                   wait_n_in,        // Wait pin in
  output logic [`CSB_ADDR_W-1:0]      addr_out,         // Address pins out
  output logic                        addr_oe_out,      // Address drive enable
  output logic [`CSB_DATA_W-1:0]      data_out,         // Data pins out
  output logic                        data_oe_out,      // Data drive enable
  output logic                        rd_n_out,         // Read strobe
  output logic                        wr_n_out,         // Store strobe
  output logic                        strb_oe_out,      // Rd/wr drive enable
  output logic                        memory_request_n_out,    // Memory request
  output logic                        memory_request_oe_out,   // Its enable
  output logic                        io_request_n_out,        // I/O request
  output logic                        io_request_oe_out,       // Its enable
  output logic                        opcode_fetch_cycle_n_out,  // Fetch indicator
  output logic                        opcode_fetch_cycle_oe_out, // Its enable
  output logic                        refresh_cycle_n_out,  // Refresh indicator
  output logic                        refresh_cycle_oe_out, // Its enable
  output logic                        halt_n_out,       // Halt indicator
  output logic                        halt_oe_out,      // Its enable
  output logic                        bus_hold_grant_n_out,  // Hold grant
  output logic                        bus_hold_grant_oe_out, // Its enable
  output logic                        wait_n_out,       // Wait pin out
  output logic                        wait_oe_out,      // Wait drive enable
  output logic                        int_oe_out,       // Interrupt pull-low
  output logic                        cycle_done_out,   // Cycle finished pulse
  output logic [`CSB_DATA_W-1:0]      cycle_rdata_out,  // Captured read data
  output logic                        take_nmi_out,     // NMI to service
  output logic                        take_int_out,     // Maskable to service
  output logic [`CSB_ADDR_W-1:0]      ext_addr_out,     // Outside master address
  output logic                        ext_rd_out,       // Outside master read
  output logic                        ext_wr_out        // Outside master write
);

  //----------------------------------------
  // Helpers
  //----------------------------------------
  function automatic logic is_io(input logic [2:0] k);
    is_io = (k == CSB_IO_RD) || (k == CSB_IO_WR) || (k == CSB_INTACK);
  endfunction

  function automatic logic is_write(input logic [2:0] k);
    is_write = (k == CSB_MEM_WR) || (k == CSB_IO_WR);
  endfunction

  function automatic logic is_m1(input logic [2:0] k);
    is_m1 = (k == CSB_FETCH) || (k == CSB_INTACK);
  endfunction

  //----------------------------------------
  // State
  //----------------------------------------
  csb_state_e                state_ff;
  csb_state_e                nxt_state;
  logic [2:0]                kind_ff;
  logic                      onchip_ff;
  logic [`CSB_ADDR_W-1:0]    addr_ff;
  logic [`CSB_DATA_W-1:0]    wdata_ff;
  logic [6:0]                refresh_cycle_n_ff;
  logic                      rd_n_ff;
  logic                      wr_n_ff;
  logic                      memory_request_n_n_ff;
  logic                      io_request_n_n_ff;
  logic                      m1_n_ff;
  logic                      refresh_cycle_n_n_ff;
  logic                      float_ff;
  logic                      grant_n_ff;
  logic                      halt_n_ff;
  logic                      done_ff;
  logic [`CSB_DATA_W-1:0]    rdata_ff;
  logic                      ext_ff;
  logic [`CSB_ADDR_W-1:0]    ext_addr_ff;
  logic                      ext_rd_ff;
  logic                      ext_wr_ff;
  logic                      wait_drv_ff;
  logic                      hold_req;

  assign hold_req = !bus_hold_request_n_in; // R17

  //----------------------------------------
  // Cycle sequencer
  //----------------------------------------
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      CSB_IDLE:
      begin
        if (hold_req)
          nxt_state = CSB_HOLD; // R22
        else if (req_valid_in)
          nxt_state = CSB_ADDR;
        else if (refresh_req_in)
          nxt_state = CSB_REFRESH_CYCLE_N;
      end
      CSB_ADDR: nxt_state = CSB_STRB;
      CSB_STRB: nxt_state = CSB_WAIT;
      CSB_WAIT:
      begin
        if (wait_n_in)
          nxt_state = CSB_IDLE; // R20
      end
      CSB_REFRESH_CYCLE_N: nxt_state = CSB_IDLE;
      CSB_HOLD:
      begin
        if (!hold_req)
          nxt_state = CSB_IDLE;
      end
      default: nxt_state = CSB_IDLE;
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
      state_ff <= CSB_IDLE;
    else
      state_ff <= nxt_state;
  end

  // Latch the request when a cycle opens
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      kind_ff   <= CSB_MEM_RD;
      onchip_ff <= 1'b0;
      addr_ff   <= `CSB_RST_ADDR;
      wdata_ff  <= `CSB_RST_DATA;
    end
    else if (state_ff == CSB_IDLE && nxt_state == CSB_ADDR)
    begin
      kind_ff   <= req_kind_in;
      onchip_ff <= req_onchip_in;
      addr_ff   <= req_addr_in; // R1
      wdata_ff  <= req_wdata_in;
    end
    else if (nxt_state == CSB_REFRESH_CYCLE_N)
      addr_ff   <= {addr_ff[15:8], 1'b0, refresh_cycle_n_ff}; // R1 R12
  end

  // Refresh counter
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
      refresh_cycle_n_ff <= `CSB_RST_REFRESH_CYCLE_N;
    else if (state_ff == CSB_REFRESH_CYCLE_N)
      refresh_cycle_n_ff <= refresh_cycle_n_ff + 7'h01;
  end

  //----------------------------------------
  // Strobes
  //----------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      memory_request_n_n_ff <= 1'b1;
      io_request_n_n_ff <= 1'b1;
      m1_n_ff   <= 1'b1;
      refresh_cycle_n_n_ff <= 1'b1;
      rd_n_ff   <= 1'b1;
      wr_n_ff   <= 1'b1;
    end
    else
    begin
      memory_request_n_n_ff <= !((nxt_state == CSB_STRB || nxt_state == CSB_WAIT) && !is_io(kind_ff))
                   && !(nxt_state == CSB_REFRESH_CYCLE_N); // R6 R12
      io_request_n_n_ff <= !((nxt_state == CSB_STRB || nxt_state == CSB_WAIT) && is_io(kind_ff)); // R8 R9
      m1_n_ff   <= !((nxt_state == CSB_ADDR || nxt_state == CSB_STRB || nxt_state == CSB_WAIT)
                   && is_m1((state_ff == CSB_IDLE) ? req_kind_in : kind_ff)); // R10 R9
      refresh_cycle_n_n_ff <= !(nxt_state == CSB_REFRESH_CYCLE_N); // R12
      rd_n_ff   <= !((nxt_state == CSB_STRB || nxt_state == CSB_WAIT) && !is_write(kind_ff));
      wr_n_ff   <= !((nxt_state == CSB_STRB || nxt_state == CSB_WAIT) && is_write(kind_ff)); // R5
    end
  end

  // Done pulse and read capture
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      done_ff  <= 1'b0;
      rdata_ff <= `CSB_RST_DATA;
    end
    else
    begin
      done_ff <= (state_ff == CSB_WAIT) && wait_n_in;
      if (state_ff == CSB_WAIT && wait_n_in)
        rdata_ff <= onchip_ff ? periph_rdata_in : data_in; // R9
    end
  end

  //----------------------------------------
  // Bus hold
  //----------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      float_ff   <= 1'b0;
      grant_n_ff <= 1'b1;
    end
    else
    begin
      float_ff   <= (nxt_state == CSB_HOLD);
      grant_n_ff <= !(float_ff && nxt_state == CSB_HOLD); // R18
    end
  end

  //----------------------------------------
  // Outside master and status
  //----------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      ext_ff      <= 1'b0;
      ext_addr_ff <= `CSB_RST_ADDR;
      ext_rd_ff   <= 1'b0;
      ext_wr_ff   <= 1'b0;
      halt_n_ff   <= 1'b1;
      wait_drv_ff <= 1'b1;
    end
    else
    begin
      ext_ff      <= ext_access_in && float_ff;
      ext_addr_ff <= addr_in; // R2
      ext_rd_ff   <= ext_ff && !rd_n_in && !io_request_n_in; // R4
      ext_wr_ff   <= ext_ff && !wr_n_in && !io_request_n_in; // R4
      halt_n_ff   <= !halt_in; // R16
      wait_drv_ff <= !emu_wait_gen_in; // R21
    end
  end

  // Data drive for writes and on-chip reads
  always_comb
  begin
    data_out    = is_write(kind_ff) ? wdata_ff : periph_rdata_in; // R3
    data_oe_out = !float_ff && (state_ff == CSB_STRB || state_ff == CSB_WAIT)
                  && (is_write(kind_ff) || onchip_ff); // R3 R5
  end

  //----------------------------------------
  // Pin drive
  //----------------------------------------
  assign addr_out                  = addr_ff;
  assign addr_oe_out               = !float_ff; // R2 R18
  assign rd_n_out                  = rd_n_ff;
  assign wr_n_out                  = wr_n_ff;
  assign strb_oe_out               = !float_ff; // R4
  assign memory_request_n_out      = memory_request_n_n_ff;
  assign memory_request_oe_out     = !float_ff; // R7
  assign io_request_n_out          = io_request_n_n_ff;
  assign io_request_oe_out         = !float_ff;
  assign opcode_fetch_cycle_n_out  = m1_n_ff;
  assign opcode_fetch_cycle_oe_out = !emu_mode_in; // R11
  assign refresh_cycle_n_out       = refresh_cycle_n_n_ff;
  assign refresh_cycle_oe_out      = !emu_mode_in; // R11
  assign halt_n_out                = halt_n_ff;
  assign halt_oe_out               = !emu_mode_in; // R11
  assign bus_hold_grant_n_out      = grant_n_ff;
  assign bus_hold_grant_oe_out     = !(emu_mode_in && FLOAT_GRANT_IN_EMU); // R19
  assign wait_n_out                = wait_drv_ff;
  assign wait_oe_out               = emu_mode_in && FLOAT_GRANT_IN_EMU; // R21
  assign cycle_done_out            = done_ff;
  assign cycle_rdata_out           = rdata_ff;
  assign ext_addr_out              = ext_addr_ff;
  assign ext_rd_out                = ext_rd_ff;
  assign ext_wr_out                = ext_wr_ff;

  csb_int_arb u_int_arb
  (
    .clk_in         (clk_in),
    .sys_rst_in     (sys_rst_in),
    .int_pin_n_in   (int_n_in),
    .periph_int_in  (periph_int_in),
    .nmi_n_in       (nmi_n_in),
    .ie_flag_in     (ie_flag_in),
    .ack_in         (cycle_done_out && kind_ff == CSB_INTACK),
    .int_pin_oe_out (int_oe_out),
    .take_nmi_out   (take_nmi_out),
    .take_int_out   (take_int_out)
  );

  //----------------------------------------
  // Assertions
  //----------------------------------------
  sequence s_hold_seen;
    hold_req && state_ff == CSB_IDLE;
  endsequence

  property p_grant_after_float;
    @(posedge clk_in) disable iff (sys_rst_in)
    !bus_hold_grant_n_out |-> !addr_oe_out && !data_oe_out && !memory_request_oe_out;
  endproperty
  a_grant_after_float: assert property (p_grant_after_float) else $error("grant while driving"); // R18

  property p_grant_timing;
    @(posedge clk_in) disable iff (sys_rst_in)
    s_hold_seen ##1 hold_req |=> !bus_hold_grant_n_out;
  endproperty
  a_grant_timing: assert property (p_grant_timing) else $error("grant late"); // R22

  property p_memory_request_n_float;
    @(posedge clk_in) disable iff (sys_rst_in)
    float_ff |-> !memory_request_oe_out && !io_request_oe_out && !strb_oe_out;
  endproperty
  a_memory_request_n_float: assert property (p_memory_request_n_float) else $error("strobes driven in hold"); // R7

  property p_refresh_cycle_n_memory_request_n;
    @(posedge clk_in) disable iff (sys_rst_in)
    !refresh_cycle_n_out |-> !memory_request_n_out && io_request_n_out;
  endproperty
  a_refresh_cycle_n_memory_request_n: assert property (p_refresh_cycle_n_memory_request_n) else $error("refresh without memory_request_n"); // R12

  property p_m1_memory_request_n;
    @(posedge clk_in) disable iff (sys_rst_in)
    (!opcode_fetch_cycle_n_out && !rd_n_out) |-> (memory_request_n_out != io_request_n_out);
  endproperty
  a_m1_memory_request_n: assert property (p_m1_memory_request_n) else $error("fetch strobe mismatch"); // R10

  property p_wr_data;
    @(posedge clk_in) disable iff (sys_rst_in)
    !wr_n_out |-> data_oe_out;
  endproperty
  a_wr_data: assert property (p_wr_data) else $error("store without data"); // R5

  property p_wait_hold;
    @(posedge clk_in) disable iff (sys_rst_in)
    (state_ff == CSB_WAIT && !wait_n_in) |=> state_ff == CSB_WAIT;
  endproperty
  a_wait_hold: assert property (p_wait_hold) else $error("left wait early"); // R20

  property p_emu_float;
    @(posedge clk_in) disable iff (sys_rst_in)
    emu_mode_in |-> !opcode_fetch_cycle_oe_out && !refresh_cycle_oe_out && !halt_oe_out;
  endproperty
  a_emu_float: assert property (p_emu_float) else $error("driven in emulation"); // R11

  property p_int_mask;
    @(posedge clk_in) disable iff (sys_rst_in)
    take_int_out |-> ie_flag_in && !take_nmi_out;
  endproperty
  a_int_mask: assert property (p_int_mask) else $error("maskable taken when masked"); // R13

endmodule
`default_nettype wire

// File: logic/csb_defines.svh
// Constants for the CPU system bus control block.
// Assumes inclusion by bare name from logic/ files.
`ifndef CSB_DEFINES_SVH
`define CSB_DEFINES_SVH

`define CSB_ADDR_W        16
`define CSB_DATA_W        8
`define CSB_RST_ADDR      16'h0000
`define CSB_RST_DATA      8'h00
`define CSB_RST_REFRESH_CYCLE_N      7'h00

`endif

// File: logic/csb_int_arb.sv
// Interrupt arbiter: non-maskable over maskable request.
// Assumes synchronous inputs, one clock.
`timescale 1ns/1ps
`default_nettype none
module csb_int_arb
  import csb_pkg::*;
(
  input  wire logic clk_in,          // System clock
  input  wire logic sys_rst_in,      // Sync reset, high
  input  wire logic int_pin_n_in,    // Maskable request pin level
  input  wire logic periph_int_in,   // On-chip peripheral request
  input  wire logic nmi_n_in,        // Non-maskable request
  input  wire logic ie_flag_in,      // Interrupt enable flag
  input  wire logic ack_in,          // Service taken
  output logic      int_pin_oe_out,  // Open-drain pull-low enable
  output logic      take_nmi_out,    // NMI pending
  output logic      take_int_out     // Maskable pending
);
  logic nmi_prev_ff;
  logic nmi_pend_ff;
  logic int_oe_ff;

  // Peripheral requests pull the shared line low
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
      int_oe_ff <= 1'b0;
    else
      int_oe_ff <= periph_int_in; // R14
  end

  // NMI is edge latched; set wins over clear
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      nmi_prev_ff <= 1'b1;
      nmi_pend_ff <= 1'b0;
    end
    else
    begin
      nmi_prev_ff <= nmi_n_in;
      if (nmi_prev_ff && !nmi_n_in)
        nmi_pend_ff <= 1'b1;
      else if (ack_in)
        nmi_pend_ff <= 1'b0;
    end
  end

  assign int_pin_oe_out = int_oe_ff;
  assign take_nmi_out   = nmi_pend_ff; // R15
  assign take_int_out   = !nmi_pend_ff && !int_pin_n_in && ie_flag_in; // R13 R15
endmodule
`default_nettype wire

// File: logic/csb_pkg.sv
// Types for the CPU system bus control block.
// Assumes csb_defines.svh is available.
package csb_pkg;

  typedef enum logic [5:0] {
    CSB_IDLE  = 6'h01,
    CSB_ADDR  = 6'h02,
    CSB_STRB  = 6'h04,
    CSB_WAIT  = 6'h08,
    CSB_REFRESH_CYCLE_N  = 6'h10,
    CSB_HOLD  = 6'h20
  } csb_state_e;

  typedef enum logic [2:0] {
    CSB_MEM_RD = 3'h0,
    CSB_MEM_WR = 3'h1,
    CSB_IO_RD  = 3'h2,
    CSB_IO_WR  = 3'h3,
    CSB_FETCH  = 3'h4,
    CSB_INTACK = 3'h5
  } csb_kind_e;

endpackage

// File: test/cpu_system_bus_control_tb.sv
// Self-checking bench for csb_bus_ctrl with a far-side partner model.
// Assumes csb_pkg compiled first and csb_defines.svh on the include path.
`timescale 1ns/1ps
`default_nettype none
module cpu_system_bus_control_tb
  import csb_pkg::*;
;
  logic clk_in, sys_rst_in, req_valid_in, req_onchip_in, refresh_req_in, halt_in, ie_flag_in, periph_int_in;
  logic ext_access_in, emu_mode_in, emu_wait_gen_in, nmi_n_in, bus_hold_request_n_in, int_n_in, wait_n_in;
  logic rd_n_in, wr_n_in, io_request_n_in, wt_pin, tb_int, mst, mrd_n, hit;
  logic addr_oe_out, data_oe_out, rd_n_out, wr_n_out, strb_oe_out, memory_request_n_out, memory_request_oe_out;
  logic io_request_n_out, io_request_oe_out, opcode_fetch_cycle_n_out, opcode_fetch_cycle_oe_out, halt_oe_out;
  logic refresh_cycle_n_out, refresh_cycle_oe_out, halt_n_out, bus_hold_grant_n_out, bus_hold_grant_oe_out;
  logic wait_n_out, wait_oe_out, int_oe_out, cycle_done_out, take_nmi_out, take_int_out, ext_rd_out, ext_wr_out;
  logic [2:0]  req_kind_in;
  logic [1:0]  nw;
  logic [15:0] req_addr_in, addr_in, addr_out, ext_addr_out, maddr;
  logic [7:0]  req_wdata_in, periph_rdata_in, data_in, data_out, cycle_rdata_out;
  int          n_fail = 0, check_count = 0, cyc = 0, seed = 34681;

  csb_bus_ctrl #(.FLOAT_GRANT_IN_EMU(1'b1)) dut (.*);

  csb_bus_partner mem (.clk_in, .nw_in(nw), .a_in(addr_out), .a_oe_in(addr_oe_out), .d_in(data_out),
    .d_oe_in(data_oe_out), .rd_n_in(rd_n_out), .wr_n_in(wr_n_out), .s_oe_in(strb_oe_out),
    .io_n_in(io_request_n_out), .io_oe_in(io_request_oe_out), .mr_n_in(memory_request_n_out),
    .m1_n_in(opcode_fetch_cycle_n_out), .ma_in(maddr), .mrd_n_in(mrd_n), .mst_in(mst), .a_out(addr_in),
    .d_out(data_in), .rd_n_out(rd_n_in), .wr_n_out(wr_n_in), .io_n_out(io_request_n_in), .wait_n_out(wt_pin));

  assign int_n_in  = !(int_oe_out | tb_int);
  assign wait_n_in = wait_oe_out ? wait_n_out : wt_pin;

  initial
  begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    if (n_fail == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  // One core cycle checked against the rules
  task automatic run(input logic [2:0] k, input logic oc, input logic [1:0] w);
    int          n;
    logic        sm, si, s1, sw, sr, sd, cm;
    logic [15:0] ca;
    @(posedge clk_in);
    req_kind_in   <= k;
    req_onchip_in <= oc;
    nw            <= w;
    {req_addr_in, req_wdata_in, periph_rdata_in} <= $random(seed);
    req_valid_in  <= 1'b1;
    n = 0;
    {sm, si, s1, sw, sr, sd, cm, ca} = '0;
    do
    begin
      @(posedge clk_in);
      req_valid_in <= 1'b0;
      #1;
      n++;
      sm |= !memory_request_n_out;
      si |= !io_request_n_out;
      s1 |= !opcode_fetch_cycle_n_out;
      sw |= !wr_n_out;
      sr |= !rd_n_out;
      sd |= data_oe_out && data_out === periph_rdata_in;
      if (!cm && (sm || si))
      begin
        cm = 1'b1;
        ca = addr_out;
      end
    end while (cycle_done_out !== 1'b1 && n < 40);
    check(16'(n), 16'(4 + w));
    if (k != CSB_MEM_WR && k != CSB_IO_WR)
      check(cycle_rdata_out, oc ? periph_rdata_in : (ca[7:0] ^ ca[15:8] ^ 8'h5A));
    if (oc && k == CSB_MEM_RD)
      check(sd, 1'b1);
    if (!oc)
    begin
      check(sm, k inside {CSB_MEM_RD, CSB_MEM_WR, CSB_FETCH});
      check(si, k inside {CSB_IO_RD, CSB_IO_WR, CSB_INTACK});
      check(s1, k inside {CSB_FETCH, CSB_INTACK});
      check({sw, sr}, (k inside {CSB_MEM_WR, CSB_IO_WR}) ? 16'h2 : 16'h1);
      if (k != CSB_INTACK)
        check(si ? {8'h00, ca[7:0]} : ca, si ? {8'h00, req_addr_in[7:0]} : req_addr_in);
    end
  endtask

  always @(posedge clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      wrap_up();
    end
  end

  always @(negedge clk_in)
  begin
    if (!sys_rst_in && !bus_hold_grant_n_out)
      check({addr_oe_out, data_oe_out, strb_oe_out, memory_request_oe_out, io_request_oe_out}, 5'h00);
    if (!refresh_cycle_n_out && refresh_cycle_oe_out)
      check(memory_request_n_out, 1'b0);
    if (!wr_n_out && strb_oe_out)
      check({data_oe_out, data_out}, {1'b1, req_wdata_in});
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    {sys_rst_in, bus_hold_request_n_in, nmi_n_in, mrd_n} = 4'hF;
    {req_valid_in, req_onchip_in, refresh_req_in, halt_in, ie_flag_in, periph_int_in, ext_access_in} = '0;
    {emu_mode_in, emu_wait_gen_in, tb_int, mst, hit} = '0;
    {req_kind_in, req_addr_in, req_wdata_in, periph_rdata_in, maddr, nw} = '0;
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    tick(1);
    check({rd_n_out, wr_n_out, memory_request_n_out, bus_hold_grant_n_out, cycle_done_out, addr_oe_out}, 6'h3D);
    for (int i = 0; i < 18; i++)
      run(3'(i % 6), 1'b0, 2'({$random(seed)} % 4));
    run(CSB_MEM_RD, 1'b1, 2'h0);
    run(CSB_IO_RD, 1'b1, 2'h1);
    run(CSB_MEM_WR, 1'b1, 2'h0);
    fork
      run(CSB_MEM_RD, 1'b0, 2'h3);
      begin
        repeat (3) @(posedge clk_in);
        bus_hold_request_n_in <= 1'b0;
      end
    join
    tick(3);
    check(bus_hold_grant_n_out, 1'b0);
    @(posedge clk_in);
    {ext_access_in, mst, mrd_n} <= 3'h6;
    maddr <= 16'($random(seed));
    tick(3);
    check(ext_addr_out, maddr);
    check({ext_rd_out, ext_wr_out, memory_request_oe_out, addr_oe_out}, 4'h8);
    @(posedge clk_in);
    {ext_access_in, mst, mrd_n, bus_hold_request_n_in} <= 4'h3;
    tick(3);
    check({bus_hold_grant_n_out, addr_oe_out}, 2'h3);
    @(posedge clk_in);
    tb_int <= 1'b1;
    tick(3);
    check(take_int_out, 1'b0);
    @(posedge clk_in);
    ie_flag_in <= 1'b1;
    tick(3);
    check(take_int_out, 1'b1);
    @(posedge clk_in);
    nmi_n_in <= 1'b0;
    ie_flag_in <= 1'b0;
    tick(3);
    check({take_nmi_out, take_int_out}, 2'h2);
    @(posedge clk_in);
    {nmi_n_in, tb_int} <= 2'h2;
    run(CSB_INTACK, 1'b0, 2'h0);
    tick(1);
    check(take_nmi_out, 1'b0);
    @(posedge clk_in);
    periph_int_in <= 1'b1;
    tick(3);
    check({int_oe_out, int_n_in}, 2'h2);
    @(posedge clk_in);
    {periph_int_in, refresh_req_in, nw} <= 4'h4;
    repeat (4)
    begin
      tick(1);
      if (!refresh_cycle_n_out)
      begin
        hit = 1'b1;
        check(addr_out[7], 1'b0);
      end
    end
    check(hit, 1'b1);
    @(posedge clk_in);
    {refresh_req_in, halt_in} <= 2'h1;
    tick(3);
    check(halt_n_out, 1'b0);
    @(posedge clk_in);
    {emu_mode_in, emu_wait_gen_in} <= 2'h3;
    tick(3);
    check({opcode_fetch_cycle_oe_out, refresh_cycle_oe_out, halt_oe_out}, 3'h0);
    check(bus_hold_grant_oe_out, 1'b0);
    check({wait_oe_out, wait_n_out}, 2'h2);
    wrap_up();
  end
endmodule
`default_nettype wire

// File: test/csb_bus_partner.sv
// Far-side model: memory and I/O answers, wait insertion, outside master pins.
// Assumes the device changes pins after rising edges; pull-ups on strobes.
`timescale 1ns/1ps
`default_nettype none
module csb_bus_partner
  import csb_pkg::*;
(
  input  wire logic        clk_in,     // System clock
  input  wire logic [1:0]  nw_in,      // Wait cycles to insert
  input  wire logic [15:0] a_in,       // Device address
  input  wire logic        a_oe_in,    // Its enable
  input  wire logic [7:0]  d_in,       // Device data
  input  wire logic        d_oe_in,    // Its enable
  input  wire logic        rd_n_in,    // Device read strobe
  input  wire logic        wr_n_in,    // Device store strobe
  input  wire logic        s_oe_in,    // Strobe enable
  input  wire logic        io_n_in,    // Device I/O request
  input  wire logic        io_oe_in,   // Its enable
  input  wire logic        mr_n_in,    // Memory request
  input  wire logic        m1_n_in,    // Fetch indicator
  input  wire logic [15:0] ma_in,      // Outside master address
  input  wire logic        mrd_n_in,   // Outside master read
  input  wire logic        mst_in,     // Outside master drives
  output logic [15:0]      a_out,      // Address pins
  output logic [7:0]       d_out,      // Data pins
  output logic             rd_n_out,   // Read pin
  output logic             wr_n_out,   // Store pin
  output logic             io_n_out,   // I/O request pin
  output logic             wait_n_out  // Wait pin
);
  logic [7:0] last_ff = 8'h00;
  logic [1:0] cnt_ff  = 2'h0;
  logic       wait_ff = 1'b1;
  logic       rsp;
  logic       act;
  assign rsp = (!rd_n_out && (!mr_n_in || !io_n_out)) || (!m1_n_in && !io_n_out);
  assign act = s_oe_in && (!mr_n_in || !io_n_out);
  assign wait_n_out = wait_ff;
  always_comb
  begin
    a_out    = a_oe_in ? a_in : (mst_in ? ma_in : ~a_in);
    rd_n_out = s_oe_in ? rd_n_in : (mst_in ? mrd_n_in : 1'b1);
    wr_n_out = s_oe_in ? wr_n_in : 1'b1;
    io_n_out = io_oe_in ? io_n_in : !mst_in;
    d_out    = d_oe_in ? d_in : (rsp ? (a_out[7:0] ^ a_out[15:8] ^ 8'h5A) : ~last_ff);
  end
  always_ff @(posedge clk_in)
    last_ff <= d_out;
  // Slow device holds wait for nw_in cycles
  always_ff @(posedge clk_in)
  begin
    cnt_ff  <= act ? cnt_ff + ((cnt_ff < nw_in) ? 2'h1 : 2'h0) : 2'h0;
    wait_ff <= !(act && cnt_ff < nw_in);
  end
endmodule
`default_nettype wire
